/* File: pkg/tdp_pkg.sv */
`default_nettype none
package tdp_pkg;
    // Register bus request carried as one struct
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tdp_bus_req_s;

    // Register offsets on the CPU register bus
    localparam logic [7:0] TDP_OFS_A_REF   = 8'hE4;
    localparam logic [7:0] TDP_OFS_B_REF   = 8'hE5;
    localparam logic [7:0] TDP_OFS_A_CNT   = 8'hE6;
    localparam logic [7:0] TDP_OFS_B_CNT   = 8'hE7;
    localparam logic [7:0] TDP_OFS_B_CTRL  = 8'hEA;
    localparam logic [7:0] TDP_OFS_A_CTRL  = 8'hEB;
    localparam logic [7:0] TDP_OFS_PEND    = 8'hEC;
    localparam logic [7:0] TDP_OFS_INT_EN  = 8'hED;

    // Control register fields (both timers share the layout)
    localparam int TDP_CTL_PAIR_BIT  = 0;
    localparam int TDP_CTL_RUN_BIT   = 1;
    localparam int TDP_CTL_CLR_BIT   = 2;
    localparam int TDP_CTL_MODE_LSB  = 3;
    localparam int TDP_CTL_CLK_LSB   = 5;

    // Pending / enable bit positions
    localparam int TDP_BIT_A_OVF = 2;
    localparam int TDP_BIT_A_MC  = 3;
    localparam int TDP_BIT_B_M   = 4;

    // Reset values
    localparam logic [7:0] TDP_RST_CTRL   = 8'h00;
    localparam logic [7:0] TDP_RST_INT_EN = 8'h00;
    localparam logic [7:0] TDP_RST_PEND   = 8'h00;
    localparam logic [7:0] TDP_RST_REF    = 8'hFF;

    // Timer A operating modes
    typedef enum logic [1:0] {
        TDP_MODE_INTERVAL = 2'h0,
        TDP_MODE_CAP_RISE = 2'h1,
        TDP_MODE_PWM      = 2'h2,
        TDP_MODE_CAP_FALL = 2'h3
    } tdp_mode_e;

    // Clock select codes: fxx/1024, /256, /64, /8, /1
    localparam logic [2:0] TDP_CLK_DIV1024 = 3'h0;
    localparam logic [2:0] TDP_CLK_DIV256  = 3'h1;
    localparam logic [2:0] TDP_CLK_DIV64   = 3'h2;
    localparam logic [2:0] TDP_CLK_DIV8    = 3'h3;
    localparam logic [2:0] TDP_CLK_DIV1    = 3'h4;
    localparam int         TDP_PRESC_W     = 10;

    // Interrupt vectors
    localparam logic [7:0] TDP_VEC_A_OVF = 8'hE0;
    localparam logic [7:0] TDP_VEC_A_MC  = 8'hDE;
    localparam logic [7:0] TDP_VEC_B_M   = 8'hE2;

    localparam logic [7:0] TDP_CNT_MAX   = 8'hFF;
    localparam logic [7:0] TDP_CNT_ZERO  = 8'h00;
endpackage : tdp_pkg
`default_nettype wire

/* File: hw/tdp_prescaler.sv */
`default_nettype none
module tdp_prescaler
    import tdp_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_sel_a,
    input  wire logic [2:0] i_sel_b,
    output logic            o_tick_a,
    output logic            o_tick_b
);
    typedef struct packed {
        logic [TDP_PRESC_W-1:0] div;
    } tdp_presc_s;

    tdp_presc_s state_q;
    tdp_presc_s state_d;

    // Pulse once every N cycles when the low bits of the shared divider are all ones
    function automatic logic tdp_tick(input logic [2:0] sel, input logic [TDP_PRESC_W-1:0] div);
        case (sel)
            TDP_CLK_DIV1024: tdp_tick = &div[9:0];
            TDP_CLK_DIV256:  tdp_tick = &div[7:0];
            TDP_CLK_DIV64:   tdp_tick = &div[5:0];
            TDP_CLK_DIV8:    tdp_tick = &div[2:0];
            default:         tdp_tick = 1'b1;
        endcase
    endfunction : tdp_tick

    // One free-running divider feeds both timers, so they stay phase locked
    always_comb begin
        state_d     = state_q;
        state_d.div = state_q.div + 1'b1;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_tick_a = tdp_tick(i_sel_a, state_q.div);
    assign o_tick_b = tdp_tick(i_sel_b, state_q.div);
endmodule : tdp_prescaler
`default_nettype wire

/* File: hw/tdp_edge_sync.sv */
`default_nettype none
module tdp_edge_sync (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    output logic      o_rise,
    output logic      o_fall
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } tdp_sync_s;

    tdp_sync_s state_q;
    tdp_sync_s state_d;

    // Two stages before any logic looks at the pin; edge detect uses stage two onward
    always_comb begin
        state_d      = state_q;
        state_d.meta = i_pin;
        state_d.sync = state_q.meta;
        state_d.last = state_q.sync;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_rise = state_q.sync & ~state_q.last;
    assign o_fall = ~state_q.sync & state_q.last;
endmodule : tdp_edge_sync
`default_nettype wire

/* File: hw/tdp_timer_pair.sv */
`default_nettype none
// Summary of operation
// - Pending bit 3 reads one while a timer A match or capture event waits.
// - Timer A raises overflow (vector E0H) and match/capture (DEH), both level one.
// - Overflow pending clears on service acknowledge or when software writes zero to bit 2.
// - Interval mode: counter equal to reference raises match, zeroes counter, keeps counting.
// - Interval mode: each match inverts the toggle output pin.
// - PWM mode: match does not clear counter; it wraps from FFH to 00H.
// - PWM output low while reference <= counter, high while reference > counter.
// - One PWM period spans 256 ticks of the selected timer clock.
// - Capture mode: chosen edge on capture pin loads counter into reference register.
// - Capture mode: overflow raises overflow event, each capture raises match/capture event.
// - Reset sets timer B control to 00H: stopped, divide-by-1024, interval disabled.
// - Writing one to timer B control bit 2 clears the timer B counter.
// - Pending bit 4 flags timer B match; only a software zero write clears it.
// - Timer B interval: counter equal to reference raises match and zeroes counter.
// - Reset sets timer A control to 00H; writing one to bit 2 clears counter.
// - Each timer clock selects system clock divided by 1024, 256, 64, 8 or 1.
module tdp_timer_pair
    import tdp_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire tdp_bus_req_s i_bus,
    output logic [7:0]        o_reg_rdata,
    input  wire logic         i_cap_pin,
    input  wire logic         i_cap_sel_pin,
    input  wire logic         i_a_ovf_ack,
    output logic              o_toggle_pin,
    output logic              o_pwm_pin,
    output logic              o_irq_level_one,
    output logic [7:0]        o_irq_level_one_vec,
    output logic              o_irq_level_two,
    output logic [7:0]        o_irq_level_two_vec
);
    typedef struct packed {
        logic [7:0] a_ctrl;
        logic [7:0] b_ctrl;
        logic [7:0] int_en;
        logic [7:0] pend;
        logic [7:0] a_ref;
        logic [7:0] b_ref;
        logic [7:0] a_cnt;
        logic [7:0] b_cnt;
        logic       toggle;
        logic       pwm;
        logic [7:0] rdata;
    } tdp_state_s;

    tdp_state_s state_q;
    tdp_state_s state_d;

    logic       tick_a;
    logic       tick_b;
    logic       cap_rise;
    logic       cap_fall;
    tdp_mode_e  a_mode;
    logic       a_run;
    logic       b_run;
    logic       a_wr_ctl;
    logic       b_wr_ctl;
    logic       pend_wr;
    logic       a_match;
    logic       a_ovf;
    logic       a_cap;
    logic       b_match;
    logic [7:0] pend_set;
    logic [7:0] pend_clr;
    logic [7:0] active;

    // Match compare shared by both counters
    function automatic logic tdp_equal(input logic [7:0] cnt, input logic [7:0] ref_val);
        tdp_equal = (cnt == ref_val);
    endfunction : tdp_equal

    tdp_prescaler u_prescaler (
        .i_mclk   (i_mclk),
        .i_rst_n  (i_rst_n),
        .i_sel_a  (state_q.a_ctrl[TDP_CTL_CLK_LSB +: 3]),
        .i_sel_b  (state_q.b_ctrl[TDP_CTL_CLK_LSB +: 3]),
        .o_tick_a (tick_a),
        .o_tick_b (tick_b)
    );

    tdp_edge_sync u_cap_sync (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_pin   (i_cap_pin),
        .o_rise  (cap_rise),
        .o_fall  (cap_fall)
    );

    // Decode of the current control state and of bus writes
    always_comb begin
        a_mode   = tdp_mode_e'(state_q.a_ctrl[TDP_CTL_MODE_LSB +: 2]);
        // The combined 16-bit arrangement is not built; timer A pair bit set simply stops both timers
        a_run    = state_q.a_ctrl[TDP_CTL_RUN_BIT] & ~state_q.a_ctrl[TDP_CTL_PAIR_BIT];
        b_run    = state_q.b_ctrl[TDP_CTL_RUN_BIT] & ~state_q.a_ctrl[TDP_CTL_PAIR_BIT];
        a_wr_ctl = i_bus.wr && (i_bus.addr == TDP_OFS_A_CTRL);
        b_wr_ctl = i_bus.wr && (i_bus.addr == TDP_OFS_B_CTRL);
        pend_wr  = i_bus.wr && (i_bus.addr == TDP_OFS_PEND);
    end

    // Counter match and overflow events, qualified by the selected prescaler tick
    always_comb begin
        a_match = a_run && tick_a && tdp_equal(state_q.a_cnt, state_q.a_ref);
        a_ovf   = a_run && tick_a && (a_mode != TDP_MODE_INTERVAL)
                  && (state_q.a_cnt == TDP_CNT_MAX);
        // Capture needs only the pin edge, so short pulses are caught between ticks
        a_cap   = a_run && (((a_mode == TDP_MODE_CAP_RISE) && cap_rise)
                  || ((a_mode == TDP_MODE_CAP_FALL) && cap_fall));
        b_match = b_run && tick_b && tdp_equal(state_q.b_cnt, state_q.b_ref);
    end

    // Pending sources and software clears; a write of zero clears, a one leaves the bit
    always_comb begin
        pend_set = '0;
        pend_clr = '0;
        pend_set[TDP_BIT_A_OVF] = a_ovf;
        pend_set[TDP_BIT_A_MC]  = (a_match && (a_mode != TDP_MODE_CAP_RISE)
                                  && (a_mode != TDP_MODE_CAP_FALL)) || a_cap;
        pend_set[TDP_BIT_B_M]   = b_match;
        if (pend_wr) begin
            pend_clr = ~i_bus.wdata;
        end
        pend_clr[TDP_BIT_A_OVF] = pend_clr[TDP_BIT_A_OVF] | i_a_ovf_ack;
    end

    // Next-state logic for registers, counters and pins
    always_comb begin
        state_d = state_q;

        // Register writes; the clear bit is a strobe and never stays set
        if (a_wr_ctl) begin
            state_d.a_ctrl = i_bus.wdata;
        end
        if (b_wr_ctl) begin
            state_d.b_ctrl = i_bus.wdata;
        end
        state_d.a_ctrl[TDP_CTL_CLR_BIT] = 1'b0;
        state_d.b_ctrl[TDP_CTL_CLR_BIT] = 1'b0;
        if (i_bus.wr && (i_bus.addr == TDP_OFS_INT_EN)) begin
            state_d.int_en = i_bus.wdata;
        end
        if (i_bus.wr && (i_bus.addr == TDP_OFS_B_REF)) begin
            state_d.b_ref = i_bus.wdata;
        end
        if (i_bus.wr && (i_bus.addr == TDP_OFS_A_REF)) begin
            state_d.a_ref = i_bus.wdata;
        end

        // Hardware set wins over a clear in the same cycle
        state_d.pend = (state_q.pend & ~pend_clr) | pend_set;

        // Timer A counter
        if (a_wr_ctl && i_bus.wdata[TDP_CTL_CLR_BIT]) begin
            state_d.a_cnt = TDP_CNT_ZERO;
        end else if (a_run && tick_a) begin
            if (a_match && (a_mode == TDP_MODE_INTERVAL)) begin
                state_d.a_cnt = TDP_CNT_ZERO;
            end else begin
                state_d.a_cnt = state_q.a_cnt + 1'b1;
            end
        end

        // Capture overrides a bus write to the reference in the same cycle
        if (a_cap) begin
            state_d.a_ref = state_q.a_cnt;
        end

        // Timer B counter
        if (b_wr_ctl && i_bus.wdata[TDP_CTL_CLR_BIT]) begin
            state_d.b_cnt = TDP_CNT_ZERO;
        end else if (b_run && tick_b) begin
            if (b_match) begin
                state_d.b_cnt = TDP_CNT_ZERO;
            end else begin
                state_d.b_cnt = state_q.b_cnt + 1'b1;
            end
        end

        // Toggle pin flips on every interval match
        if (a_match && (a_mode == TDP_MODE_INTERVAL)) begin
            state_d.toggle = ~state_q.toggle;
        end

        // PWM level follows the next counter value so the pin tracks it without lag
        if (a_mode == TDP_MODE_PWM) begin
            state_d.pwm = (state_q.a_ref > state_d.a_cnt);
        end else begin
            state_d.pwm = 1'b0;
        end

        // Registered read data; unmapped offsets read as zero
        state_d.rdata = 8'h00;
        if (i_bus.rd) begin
            case (i_bus.addr)
                TDP_OFS_A_CTRL: state_d.rdata = state_q.a_ctrl;
                TDP_OFS_B_CTRL: state_d.rdata = state_q.b_ctrl;
                TDP_OFS_INT_EN: state_d.rdata = state_q.int_en;
                TDP_OFS_PEND:   state_d.rdata = state_q.pend;
                TDP_OFS_A_REF:  state_d.rdata = state_q.a_ref;
                TDP_OFS_B_REF:  state_d.rdata = state_q.b_ref;
                TDP_OFS_A_CNT:  state_d.rdata = state_q.a_cnt;
                TDP_OFS_B_CNT:  state_d.rdata = state_q.b_cnt;
                default:        state_d.rdata = 8'h00;
            endcase
        end
    end

    // State register; reset leaves both timers stopped on the slowest clock
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q.a_ctrl <= TDP_RST_CTRL;
            state_q.b_ctrl <= TDP_RST_CTRL;
            state_q.int_en <= TDP_RST_INT_EN;
            state_q.pend   <= TDP_RST_PEND;
            state_q.a_ref  <= TDP_RST_REF;
            state_q.b_ref  <= TDP_RST_REF;
            state_q.a_cnt  <= TDP_CNT_ZERO;
            state_q.b_cnt  <= TDP_CNT_ZERO;
            state_q.toggle <= 1'b0;
            state_q.pwm    <= 1'b0;
            state_q.rdata  <= 8'h00;
        end else begin
            state_q <= state_d;
        end
    end

    // Interrupt requests: pending bits gated by enables; match/capture vector wins on level one
    always_comb begin
        active              = state_q.pend & state_q.int_en;
        o_irq_level_one     = active[TDP_BIT_A_OVF] | active[TDP_BIT_A_MC];
        o_irq_level_one_vec = active[TDP_BIT_A_MC] ? TDP_VEC_A_MC : TDP_VEC_A_OVF;
        o_irq_level_two     = active[TDP_BIT_B_M];
        o_irq_level_two_vec = TDP_VEC_B_M;
    end

    // Capture pin routing select is outside this block; it is accepted but not needed here
    logic cap_sel_unused;
    assign cap_sel_unused = i_cap_sel_pin;

    assign o_reg_rdata  = state_q.rdata;
    assign o_toggle_pin = state_q.toggle;
    assign o_pwm_pin    = state_q.pwm;
endmodule : tdp_timer_pair
`default_nettype wire

/* File: sim/tdp_timer_pair_props.sv */
`default_nettype none
module tdp_timer_pair_props
    import tdp_pkg::*;
(
    input  wire logic         i_mclk,
    input  wire logic         i_rst_n,
    input  wire tdp_bus_req_s i_bus,
    input  wire logic         i_a_ovf_ack,
    input  wire logic [7:0]   o_reg_rdata,
    input  wire logic         o_toggle_pin,
    input  wire logic         o_pwm_pin,
    input  wire logic         o_irq_level_one,
    input  wire logic [7:0]   o_irq_level_one_vec,
    input  wire logic         o_irq_level_two,
    input  wire logic [7:0]   o_irq_level_two_vec
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    typedef struct packed {
        logic [7:0] a_ctl;
        logic [7:0] en;
    } tdp_shadow_s;
    tdp_shadow_s sh_q;
    tdp_shadow_s sh_d;
    logic        wr_ec;
    logic        wr_ed;
    // Shadow copies of mode and enable writes; outputs alone do not show the mode
    assign wr_ec = i_bus.wr && i_bus.addr == TDP_OFS_PEND;
    assign wr_ed = i_bus.wr && i_bus.addr == TDP_OFS_INT_EN;
    always_comb begin
        sh_d = sh_q;
        if (i_bus.wr && i_bus.addr == TDP_OFS_A_CTRL) sh_d.a_ctl = i_bus.wdata;
        if (wr_ed) sh_d.en = i_bus.wdata;
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) sh_q <= '0;
        else sh_q <= sh_d;
    end
    vec_two_a: assert property (o_irq_level_two_vec == TDP_VEC_B_M)
        else $error("level two vector wrong");
    vec_one_a: assert property ((o_irq_level_one_vec == TDP_VEC_A_MC) ?
        (o_irq_level_one && sh_q.en[TDP_BIT_A_MC]) : (o_irq_level_one_vec == TDP_VEC_A_OVF))
        else $error("level one vector wrong");
    two_enable_a: assert property (o_irq_level_two |-> sh_q.en[TDP_BIT_B_M])
        else $error("level two request while disabled");
    one_enable_a: assert property (o_irq_level_one |-> sh_q.en[TDP_BIT_A_OVF] || sh_q.en[TDP_BIT_A_MC])
        else $error("level one request while disabled");
    ctl_read_a: assert property ($past(i_bus.rd && !i_bus.wr && i_bus.addr == TDP_OFS_A_CTRL) |->
        o_reg_rdata == (sh_q.a_ctl & 8'hFB))
        else $error("control readback wrong");
    pwm_off_a: assert property (sh_q.a_ctl[4:3] != TDP_MODE_PWM && $past(sh_q.a_ctl[4:3]) != TDP_MODE_PWM
        |-> !o_pwm_pin)
        else $error("pwm pin high outside pwm mode");
    toggle_mode_a: assert property ($changed(o_toggle_pin) |-> $past(sh_q.a_ctl[4:3]) == TDP_MODE_INTERVAL)
        else $error("toggle moved outside interval mode");
    mc_hold_a: assert property ($fell(o_irq_level_one_vec == TDP_VEC_A_MC) |->
        $past((wr_ec || wr_ed) && !i_bus.wdata[TDP_BIT_A_MC]))
        else $error("match pending dropped by itself");
    b_hold_a: assert property ($fell(o_irq_level_two) |-> $past((wr_ec || wr_ed) && !i_bus.wdata[TDP_BIT_B_M]))
        else $error("timer b pending dropped by itself");
    ovf_clear_a: assert property ($fell(o_irq_level_one) |-> $past(i_a_ovf_ack || wr_ec || wr_ed))
        else $error("level one dropped without cause");
    cover property (o_irq_level_two);
    cover property ($changed(o_toggle_pin));
    cover property ($rose(o_pwm_pin));
endmodule : tdp_timer_pair_props
bind tdp_timer_pair tdp_timer_pair_props tdp_timer_pair_props_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_bus(i_bus), .i_a_ovf_ack(i_a_ovf_ack), .o_reg_rdata(o_reg_rdata), .o_toggle_pin(o_toggle_pin),
    .o_pwm_pin(o_pwm_pin), .o_irq_level_one(o_irq_level_one), .o_irq_level_one_vec(o_irq_level_one_vec),
    .o_irq_level_two(o_irq_level_two), .o_irq_level_two_vec(o_irq_level_two_vec));
`default_nettype wire

/* File: sim/tdp_cap_source.sv */
`default_nettype none
// Far-end source of the capture pin, with the port zero routing held at code 00
module tdp_cap_source (
    input  wire logic i_mclk,
    output logic      o_pin,
    output logic      o_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_pin = 1'b0;
    assign o_sel = 1'b0; // Capture pin selected
    // Moves a few ns past the edge, as an unsynchronised source would
    task automatic drive(input logic v);
        @(posedge i_mclk);
        #3 o_pin = v;
    endtask : drive
endmodule : tdp_cap_source
`default_nettype wire

/* File: sim/tdp_timer_pair_tb.sv */
`default_nettype none
module tdp_timer_pair_tb
    import tdp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_mclk, i_rst_n, i_cap_pin, i_cap_sel_pin, i_a_ovf_ack, tg;
    logic         rd_seen = 1'b0;
    tdp_bus_req_s i_bus;
    logic [7:0]   o_reg_rdata, o_irq_level_one_vec, o_irq_level_two_vec, r, w;
    logic         o_toggle_pin, o_pwm_pin, o_irq_level_one, o_irq_level_two;
    logic [23:0]  e;
    logic [23:0]  expq[$];
    logic [31:0]  seed;
    int           fails = 0, comparisons = 0, n;
    int           dv [5] = '{1024, 256, 64, 8, 1};

    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    tdp_timer_pair tdp_timer_pair_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(i_bus),
        .o_reg_rdata(o_reg_rdata), .i_cap_pin(i_cap_pin), .i_cap_sel_pin(i_cap_sel_pin),
        .i_a_ovf_ack(i_a_ovf_ack), .o_toggle_pin(o_toggle_pin), .o_pwm_pin(o_pwm_pin),
        .o_irq_level_one(o_irq_level_one), .o_irq_level_one_vec(o_irq_level_one_vec),
        .o_irq_level_two(o_irq_level_two), .o_irq_level_two_vec(o_irq_level_two_vec));
    tdp_cap_source tdp_cap_source_i (.i_mclk(i_mclk), .o_pin(i_cap_pin), .o_sel(i_cap_sel_pin));

    // Range compare; a single value is a range of one, unknowns never pass
    task automatic chk(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
        comparisons++;
        if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
            fails++;
            $display("BAD %s expected %0h..%0h seen %0h", what, lo, hi, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_mclk);
        i_bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        @(posedge i_mclk);
        i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        expq.push_back({a, lo, hi});
        @(posedge i_mclk);
        i_bus.rd <= 1'b0;
    endtask : rd

    // Read answers arrive one cycle after the strobe; pair with the oldest note
    always @(posedge i_mclk) begin
        if (rd_seen) begin
            e = expq.pop_front();
            chk($sformatf("reg %h", e[23:16]), e[15:8], e[7:0], o_reg_rdata);
        end
        rd_seen <= i_bus.rd;
    end

    task automatic report_and_stop();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Whole sequence needs about 15k cycles; this leaves ample slack
    initial begin
        repeat (40000) @(posedge i_mclk);
        fails++;
        report_and_stop();
    end

    initial begin
        seed = 32'hEF2B12B2;
        i_bus = '0;
        i_rst_n = 1'b0;
        i_a_ovf_ack = 1'b0;
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // Reset state, an unmapped place and a stopped counter
        rd(TDP_OFS_B_CTRL, 8'h00, 8'h00);
        rd(TDP_OFS_A_CTRL, 8'h00, 8'h00);
        rd(TDP_OFS_PEND, 8'h00, 8'h00);
        rd(TDP_OFS_B_REF, 8'hFF, 8'hFF);
        rd(8'hE8, 8'h00, 8'h00);
        rd(TDP_OFS_B_CNT, 8'h00, 8'h00);
        // Every clock code: about ten ticks, then hold, then clear while stopped
        wr(TDP_OFS_B_REF, 8'hFF);
        for (int k = 0; k < 5; k++) begin
            wr(TDP_OFS_B_CTRL, {3'(k), 5'h06});
            repeat (10 * dv[k]) @(posedge i_mclk);
            wr(TDP_OFS_B_CTRL, {3'(k), 5'h00});
            rd(TDP_OFS_B_CNT, 8'd9, 8'd12);
            repeat (20) @(posedge i_mclk);
            rd(TDP_OFS_B_CNT, 8'd9, 8'd12);
            wr(TDP_OFS_B_CTRL, 8'h04);
            rd(TDP_OFS_B_CNT, 8'h00, 8'h00);
        end
        // Timer B interval with its interrupt
        wr(TDP_OFS_B_REF, 8'h03);
        wr(TDP_OFS_INT_EN, 8'h10);
        wr(TDP_OFS_B_CTRL, 8'h86);
        repeat (40) @(posedge i_mclk);
        chk("irq two", 8'h01, 8'h01, {7'h00, o_irq_level_two});
        chk("vector two", TDP_VEC_B_M, TDP_VEC_B_M, o_irq_level_two_vec);
        wr(TDP_OFS_B_CTRL, 8'h80);
        rd(TDP_OFS_B_CNT, 8'h00, 8'h03);
        rd(TDP_OFS_PEND, 8'h10, 8'h10);
        wr(TDP_OFS_PEND, 8'hEF);
        rd(TDP_OFS_PEND, 8'h00, 8'h00);
        // Timer A interval, random reference, count toggles over twelve periods
        r = 8'd2 + 8'($unsigned($random(seed)) % 8);
        wr(TDP_OFS_A_REF, r);
        wr(TDP_OFS_INT_EN, 8'h08);
        wr(TDP_OFS_A_CTRL, 8'h86);
        n = 0;
        tg = o_toggle_pin;
        repeat (12 * (r + 1)) begin
            @(posedge i_mclk);
            if (o_toggle_pin !== tg) n++;
            tg = o_toggle_pin;
        end
        chk("toggle flips", 8'd11, 8'd13, 8'(n));
        chk("vector one", TDP_VEC_A_MC, TDP_VEC_A_MC, o_irq_level_one_vec);
        wr(TDP_OFS_A_CTRL, 8'h80);
        rd(TDP_OFS_A_CNT, 8'h00, r);
        rd(TDP_OFS_PEND, 8'h08, 8'h08);
        wr(TDP_OFS_PEND, 8'hF7);
        // PWM: reference 40h gives a quarter high over two periods
        wr(TDP_OFS_A_REF, 8'h40);
        wr(TDP_OFS_A_CTRL, 8'h96);
        n = 0;
        repeat (512) begin
            @(posedge i_mclk);
            if (o_pwm_pin === 1'b1) n++;
        end
        chk("pwm high", 8'd126, 8'd130, 8'(n));
        wr(TDP_OFS_A_CTRL, 8'h80);
        rd(TDP_OFS_PEND, 8'h0C, 8'h0C);
        wr(TDP_OFS_INT_EN, 8'h04);
        // The enable lands at the edge that ends the write, so look one edge later
        @(posedge i_mclk);
        chk("vector one", TDP_VEC_A_OVF, TDP_VEC_A_OVF, o_irq_level_one_vec);
        chk("irq one", 8'h01, 8'h01, {7'h00, o_irq_level_one});
        wr(TDP_OFS_PEND, 8'hF7);
        rd(TDP_OFS_PEND, 8'h04, 8'h04);
        @(posedge i_mclk);
        i_a_ovf_ack <= 1'b1;
        @(posedge i_mclk);
        i_a_ovf_ack <= 1'b0;
        rd(TDP_OFS_PEND, 8'h00, 8'h00);
        chk("irq one", 8'h00, 8'h00, {7'h00, o_irq_level_one});
        // Capture on a rising edge after a random wait
        w = 8'd20 + 8'($unsigned($random(seed)) % 100);
        wr(TDP_OFS_A_CTRL, 8'h8E);
        repeat (w) @(posedge i_mclk);
        tdp_cap_source_i.drive(1'b1);
        repeat (8) @(posedge i_mclk);
        rd(TDP_OFS_A_REF, w, w + 8'd8);
        rd(TDP_OFS_PEND, 8'h08, 8'h08);
        // Capture on a falling edge after one overflow
        wr(TDP_OFS_PEND, 8'h00);
        wr(TDP_OFS_A_CTRL, 8'h9E);
        repeat (300) @(posedge i_mclk);
        tdp_cap_source_i.drive(1'b0);
        repeat (8) @(posedge i_mclk);
        rd(TDP_OFS_A_REF, 8'd44, 8'd56);
        rd(TDP_OFS_PEND, 8'h0C, 8'h0C);
        wr(TDP_OFS_A_CTRL, 8'h80);
        wr(TDP_OFS_PEND, 8'hFB);
        rd(TDP_OFS_PEND, 8'h08, 8'h08);
        repeat (4) @(posedge i_mclk);
        report_and_stop();
    end
endmodule : tdp_timer_pair_tb
`default_nettype wire
